//--- rtl/acm_consts.svh
// constants for the converter control block: register indices, fields, counts
// assumes inclusion by rtl and testbench files; byte address is four times the index
`ifndef ACM_CONSTS_SVH
`define ACM_CONSTS_SVH

// register indices and byte addresses
`define ACM_IDX_CSA          8'h06
`define ACM_IDX_CRS          8'h07
`define ACM_IDX_RES_LO       8'h04
`define ACM_IDX_RES_HI       8'h05
`define ACM_IDX_CSB          8'h08
`define ACM_ADDR_W           8
`define ACM_ADDR_CSA         8'h18
`define ACM_ADDR_CRS         8'h1C
`define ACM_ADDR_RES_LO      8'h10
`define ACM_ADDR_RES_HI      8'h14
`define ACM_ADDR_CSB         8'h20

// reset values
`define ACM_RST_CSA          8'h00
`define ACM_RST_CRS          8'h00
`define ACM_RST_CSB          8'h00

// control_status_a_register fields
`define ACM_CSA_EN           7
`define ACM_CSA_START        6
`define ACM_CSA_AUTO         5
`define ACM_CSA_FLAG         4
`define ACM_CSA_IE           3
`define ACM_CSA_DIV_HI       2
`define ACM_CSA_DIV_LO       0

// channel_reference_register fields
`define ACM_CRS_REF_HI       7
`define ACM_CRS_REF_LO       6
`define ACM_CRS_LEFT         5
`define ACM_CRS_CHAN_HI      4
`define ACM_CRS_CHAN_LO      0

// control_status_b_register fields
`define ACM_CSB_REF_EXT      7
`define ACM_CSB_CHAN_TOP     6
`define ACM_CSB_GAIN_HI      5
`define ACM_CSB_TRIG_HI      2
`define ACM_CSB_TRIG_LO      0

// conversion lengths in converter clocks
`define ACM_LEN_LONG         5'd25
`define ACM_LEN_NORMAL       5'd13

// channel code landmarks
`define ACM_CH_SE_LAST       6'h0A
`define ACM_CH_DIFF_LAST     6'h1D
`define ACM_CH_BANDGAP       6'h1E
`define ACM_CH_GROUND        6'h1F
`define ACM_CH_SELF_FIRST    6'h3A
`define ACM_CH_TEMP          6'h3F
`define ACM_UNITY_MASK       32'h2529_9000

// trigger source that means free running
`define ACM_TRIG_FREE        3'h0
`define ACM_APB_ERR_NONE     1'b0

`endif

//--- rtl/acm_pkg.sv
// types shared by the converter control block
// assumes nothing beyond the consts header
package acm_pkg;

    typedef enum logic [0:0] {
        ACM_IDLE = 1'b0,
        ACM_CONV = 1'b1
    } acm_state_t;

    typedef enum logic [2:0] {
        ACM_REF_SUPPLY      = 3'b000,
        ACM_REF_EXTERNAL    = 3'b001,
        ACM_REF_INT_LOW     = 3'b010,
        ACM_REF_RESERVED    = 3'b011,
        ACM_REF_INT_HIGH    = 3'b100,
        ACM_REF_INT_HIGH_BP = 3'b101
    } acm_ref_t;

    typedef enum logic [1:0] {
        ACM_GAIN_1X  = 2'b00,
        ACM_GAIN_8X  = 2'b01,
        ACM_GAIN_20X = 2'b10,
        ACM_GAIN_32X = 2'b11
    } acm_gain_t;

endpackage

//--- rtl/acm_prescaler.sv
// converter clock prescaler: one-cycle enable at core_clk / division factor
// assumes div_code is steady while run is high; counter restarts when run drops
`timescale 1ns/1ps
`include "acm_consts.svh"
module acm_prescaler #(
    parameter int CNT_W = 7
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // control
    input  wire logic             run,
    input  wire logic [2:0]       div_code,
    // converter clock enable
    output logic                  tick
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] limit;
    logic             wrap;

    // codes 0 and 1 both divide by two
    assign limit = (div_code == 3'h0) ? CNT_W'(1) : CNT_W'((1 << div_code) - 1);
    assign wrap  = (cnt_r == limit);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= (!run || wrap) ? '0 : cnt_r + CNT_W'(1);
            tick  <= run && wrap;
        end
    end

endmodule

//--- rtl/acm_top.sv
// converter control: channel/reference select, control/status, result view, apb slave
// assumes the analog core presents result_data valid on the last converter tick, while conv_active is still high
// Notes on behaviour
// - reference code from two select bits plus extension bit, 011 reserved.
// - reference writes during a conversion apply only after it completes.
// - after a reference change the next conversion lasts 25 converter clocks.
// - left-adjust bit reshapes the result view at once, even mid-conversion.
// - six-bit channel code picks single-ended pins 0-10, 1.1 V node, ground.
// - differential codes also pick gain, fixed or chosen by gain select bit.
// - codes routing one pin to both inputs are allowed for offset measuring.
// - channel code 111111 selects and enables the temperature sensor.
// - channel writes during a conversion apply only after it completes.
// - enable turns converter on; clearing it aborts any running conversion.
// - writing start begins a conversion; free running continues by itself.
// - first conversion after enabling or a reference change takes 25 clocks, others take 13.
// - start bit reads one while converting; writing zero does nothing.
// - auto-trigger starts a conversion on each rising edge of chosen source.
// - done flag sets when a conversion ends and the result is stored.
// - done flag clears on interrupt vector or write of one; zero keeps it.
// - interrupt request while flag, enable bit and global enable all set.
// - divider field gives 2,2,4,8,16,32,64,128 from the system clock.
// - right-adjusted result fills low byte and two high bits, rest zero.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "acm_consts.svh"
module acm_top
    import acm_pkg::*;
#(
    parameter int RES_W  = 10,
    parameter int TRIG_N = 8
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // processor side
    input  wire logic              global_irq_enable,
    input  wire logic              irq_vector_taken,
    output logic                   conversion_irq,
    // trigger sources
    input  wire logic [TRIG_N-1:0] trigger_in,
    // analog core
    input  wire logic [RES_W-1:0]  result_data,
    output logic                   converter_on,
    output logic                   conv_active,
    output logic                   conv_init,
    output logic                   conv_clk_en,
    output acm_ref_t               ref_source,
    output logic [5:0]             channel_code,
    output logic                   channel_diff,
    output acm_gain_t              channel_gain,
    output logic                   temp_sensor_en
);

    // register state
    logic [7:0]       csa_r;
    logic [7:0]       crs_r;
    logic [7:0]       csb_r;
    logic [RES_W-1:0] result_r;
    acm_state_t       state_r;
    logic [4:0]       cnt_r;
    logic [4:0]       len_r;
    logic             first_pending_r;
    logic             ref_changed_r;
    logic             trig_prev_r;
    logic             done_flag_r;
    logic             start_bit_r;
    logic             en_r;
    logic [2:0]       app_ref_r;
    logic [5:0]       app_chan_r;
    logic             app_gain_hi_r;

    // bus decode
    wire setup_ph   = psel && !penable;
    wire access_ok  = psel && penable && pready;
    wire wr_fire    = access_ok && pwrite;
    wire sel_csa    = (paddr == `ACM_ADDR_CSA);
    wire sel_crs    = (paddr == `ACM_ADDR_CRS);
    wire sel_csb    = (paddr == `ACM_ADDR_CSB);
    wire sel_lo     = (paddr == `ACM_ADDR_RES_LO);
    wire sel_hi     = (paddr == `ACM_ADDR_RES_HI);
    wire mapped     = sel_csa || sel_crs || sel_csb || sel_lo || sel_hi;
    wire wr_csa     = wr_fire && sel_csa;
    wire wr_crs     = wr_fire && sel_crs;
    wire wr_csb     = wr_fire && sel_csb;

    // control decode
    wire       en_nxt     = wr_csa ? pwdata[`ACM_CSA_EN] : en_r;
    wire       en_rise    = en_nxt && !en_r;
    wire       auto_en    = csa_r[`ACM_CSA_AUTO];
    wire [2:0] div_code   = csa_r[`ACM_CSA_DIV_HI:`ACM_CSA_DIV_LO];
    wire [2:0] trig_sel   = csb_r[`ACM_CSB_TRIG_HI:`ACM_CSB_TRIG_LO];
    wire       free_run   = auto_en && (trig_sel == `ACM_TRIG_FREE);
    wire       tick;

    // requested settings
    wire [2:0] req_ref    = {csb_r[`ACM_CSB_REF_EXT], crs_r[`ACM_CRS_REF_HI],
                             crs_r[`ACM_CRS_REF_LO]};
    wire [5:0] req_chan   = {csb_r[`ACM_CSB_CHAN_TOP],
                             crs_r[`ACM_CRS_CHAN_HI:`ACM_CRS_CHAN_LO]};
    wire       left_adj   = crs_r[`ACM_CRS_LEFT];

    // trigger edge, free-running source counts as no edge source
    wire       trig_now   = trigger_in[trig_sel];
    wire       trig_edge  = auto_en && !free_run && trig_now && !trig_prev_r;

    wire       busy       = (state_r == ACM_CONV);
    wire       last_tick  = busy && tick && (cnt_r == len_r - 5'd1);
    wire       sw_start   = wr_csa && pwdata[`ACM_CSA_START];
    // starts while busy are dropped rather than queued
    wire       start_req  = !busy && en_nxt && (sw_start || trig_edge);
    wire       restart    = last_tick && free_run && en_r;
    wire       abort      = busy && !en_nxt;
    wire       ref_diff   = (req_ref != app_ref_r);
    wire       want_long  = first_pending_r || en_rise || ref_changed_r || ref_diff;

    // done flag: hardware set beats software or vector clear
    wire       flag_clr   = irq_vector_taken ||
                            (wr_csa && pwdata[`ACM_CSA_FLAG]);
    wire       flag_nxt   = last_tick || (done_flag_r && !flag_clr);

    // reference decode
    acm_ref_t ref_dec;
    always_comb begin
        unique case (app_ref_r)
            3'b000, 3'b100: ref_dec = ACM_REF_SUPPLY;
            3'b001, 3'b101: ref_dec = ACM_REF_EXTERNAL;
            3'b010:         ref_dec = ACM_REF_INT_LOW;
            3'b011:         ref_dec = ACM_REF_RESERVED;
            3'b110:         ref_dec = ACM_REF_INT_HIGH;
            3'b111:         ref_dec = ACM_REF_INT_HIGH_BP;
        endcase
    end

    // channel decode
    wire lo_diff    = (app_chan_r > `ACM_CH_SE_LAST) && (app_chan_r <= `ACM_CH_DIFF_LAST);
    wire hi_diff    = app_chan_r[5] && (app_chan_r != `ACM_CH_TEMP);
    wire diff_dec   = lo_diff || hi_diff;
    wire [31:0] unity_sh = `ACM_UNITY_MASK >> app_chan_r[4:0];
    wire lo_unity   = unity_sh[0];
    // self-paired codes at the top end are all the high-gain pair
    wire hi_lowgain = app_chan_r[0] && (app_chan_r < `ACM_CH_SELF_FIRST);
    acm_gain_t gain_dec;
    always_comb begin
        if (lo_diff) begin
            gain_dec = lo_unity ? ACM_GAIN_1X : ACM_GAIN_20X;
        end else if (hi_diff && hi_lowgain) begin
            gain_dec = app_gain_hi_r ? ACM_GAIN_8X : ACM_GAIN_1X;
        end else if (hi_diff) begin
            gain_dec = app_gain_hi_r ? ACM_GAIN_32X : ACM_GAIN_20X;
        end else begin
            gain_dec = ACM_GAIN_1X;
        end
    end

    // result view follows the adjust bit combinationally
    wire [7:0] res_lo = left_adj ? {result_r[1:0], 6'h00} : result_r[7:0];
    wire [7:0] res_hi = left_adj ? result_r[9:2] : {6'h00, result_r[9:8]};

    wire [7:0] csa_view = {en_r, start_bit_r, csa_r[`ACM_CSA_AUTO], done_flag_r,
                           csa_r[`ACM_CSA_IE:0]};
    wire [7:0] rd_byte  = sel_csa ? csa_view :
                          sel_crs ? crs_r    :
                          sel_csb ? csb_r    :
                          sel_lo  ? res_lo   :
                          sel_hi  ? res_hi   : 8'h00;

    acm_prescaler #(
        .CNT_W    (7)
    ) u_prescaler (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (en_r),
        .div_code (div_code),
        .tick     (tick)
    );

    // apb: no wait states, answer prepared in the setup cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= `ACM_APB_ERR_NONE;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph && !mapped;
            if (setup_ph) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // software registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            csa_r <= `ACM_RST_CSA;
            crs_r <= `ACM_RST_CRS;
            csb_r <= `ACM_RST_CSB;
            en_r  <= 1'b0;
        end else begin
            en_r <= en_nxt;
            if (wr_csa) begin
                csa_r <= pwdata[7:0];
            end
            if (wr_crs) begin
                crs_r <= pwdata[7:0];
            end
            if (wr_csb) begin
                csb_r <= pwdata[7:0];
            end
        end
    end

    // settings reach the analog side only between conversions
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            app_ref_r     <= 3'b000;
            app_chan_r    <= 6'h00;
            app_gain_hi_r <= 1'b0;
            ref_changed_r <= 1'b0;
        end else if (!busy || last_tick) begin
            // free running never idles, so the end of each conversion applies too
            app_ref_r     <= req_ref;
            app_chan_r    <= req_chan;
            app_gain_hi_r <= csb_r[`ACM_CSB_GAIN_HI];
            ref_changed_r <= (start_req || restart) ? 1'b0 : (ref_changed_r || ref_diff);
        end else if (ref_diff) begin
            ref_changed_r <= 1'b1;
        end
    end

    // conversion sequencer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r         <= ACM_IDLE;
            cnt_r           <= 5'd0;
            len_r           <= `ACM_LEN_NORMAL;
            first_pending_r <= 1'b0;
            start_bit_r     <= 1'b0;
        end else begin
            if (abort || (last_tick && !restart)) begin
                state_r     <= ACM_IDLE;
                start_bit_r <= 1'b0;
            end else if (start_req) begin
                state_r     <= ACM_CONV;
                start_bit_r <= 1'b1;
                cnt_r       <= 5'd0;
                len_r       <= want_long ? `ACM_LEN_LONG : `ACM_LEN_NORMAL;
            end else if (restart) begin
                cnt_r       <= 5'd0;
                len_r       <= (ref_changed_r || ref_diff) ? `ACM_LEN_LONG : `ACM_LEN_NORMAL;
            end else if (busy && tick) begin
                cnt_r       <= cnt_r + 5'd1;
            end
            if (start_req) begin
                first_pending_r <= 1'b0;
            end else if (en_rise) begin
                first_pending_r <= 1'b1;
            end
        end
    end

    // flag, result, trigger history
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done_flag_r <= 1'b0;
            result_r    <= '0;
            trig_prev_r <= 1'b0;
        end else begin
            done_flag_r <= flag_nxt;
            trig_prev_r <= trig_now;
            if (last_tick) begin
                result_r <= result_data;
            end
        end
    end

    // analog core and interrupt outputs
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            conversion_irq <= 1'b0;
            converter_on   <= 1'b0;
            conv_active    <= 1'b0;
            conv_init      <= 1'b0;
            conv_clk_en    <= 1'b0;
            ref_source     <= ACM_REF_SUPPLY;
            channel_code   <= 6'h00;
            channel_diff   <= 1'b0;
            channel_gain   <= ACM_GAIN_1X;
            temp_sensor_en <= 1'b0;
        end else begin
            conversion_irq <= flag_nxt && csa_r[`ACM_CSA_IE] && global_irq_enable;
            converter_on   <= en_r;
            conv_active    <= busy;
            conv_init      <= busy && (len_r == `ACM_LEN_LONG);
            conv_clk_en    <= tick;
            ref_source     <= ref_dec;
            channel_code   <= app_chan_r;
            channel_diff   <= diff_dec;
            channel_gain   <= gain_dec;
            temp_sensor_en <= (app_chan_r == `ACM_CH_TEMP);
        end
    end

endmodule

//--- testbench/acm_core_model.sv
// analog core stand-in: holds a sample while converting, churns it when idle
// assumes conv_active frames every conversion
`timescale 1ns/1ps
module acm_core_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // control from the block
    input  wire logic       conv_active,
    // data to the block
    output logic [9:0]      result_data,
    output logic [9:0]      sample_val
);
    logic active_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            active_q    <= 1'b0;
            sample_val  <= 10'h2C5;
            result_data <= 10'h000;
        end else begin
            active_q <= conv_active;
            if (conv_active && !active_q) begin
                sample_val <= sample_val + 10'h0B3;
            end
            // idle output toggles so a late capture cannot look right
            result_data <= conv_active ? sample_val : ~result_data;
        end
    end
endmodule

//--- testbench/acm_checker.sv
// concurrent checks on the converter control block ports
// assumes binding onto acm_top; single clock domain
`timescale 1ns/1ps
`include "acm_consts.svh"
module acm_checker
    import acm_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // apb
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic [7:0] paddr,
    input  wire logic       pready,
    input  wire logic       pslverr,
    // processor side
    input  wire logic       global_irq_enable,
    input  wire logic       conversion_irq,
    // analog core
    input  wire logic       converter_on,
    input  wire logic       conv_active,
    input  wire logic       conv_init,
    input  wire logic       conv_clk_en,
    input  wire acm_ref_t   ref_source,
    input  wire logic [5:0] channel_code,
    input  wire logic       channel_diff,
    input  wire acm_gain_t  channel_gain,
    input  wire logic       temp_sensor_en
);
    localparam logic [31:0] UNITY = `ACM_UNITY_MASK;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence ready_pulse;
        pready ##1 !pready;
    endsequence

    apb_answer_a: assert property (apb_setup |=> ready_pulse)
        else $error("apb answer not one cycle after setup");
    slverr_map_a: assert property (pready |-> pslverr == !(paddr inside {`ACM_ADDR_CSA,
        `ACM_ADDR_CRS, `ACM_ADDR_RES_LO, `ACM_ADDR_RES_HI, `ACM_ADDR_CSB}))
        else $error("error response does not match address map");
    irq_cause_a: assert property (conversion_irq |-> $past(global_irq_enable))
        else $error("interrupt without global enable");
    temp_decode_a: assert property (temp_sensor_en == (channel_code == `ACM_CH_TEMP))
        else $error("sensor enable disagrees with channel");
    diff_decode_a: assert property (channel_diff == ((channel_code >= 6'h0B
        && channel_code <= `ACM_CH_DIFF_LAST) || (channel_code >= 6'h20 && channel_code <= 6'h3E)))
        else $error("differential flag wrong for channel");
    fixed_gain_a: assert property (channel_diff && channel_code <= `ACM_CH_DIFF_LAST
        |-> channel_gain == (UNITY[channel_code[4:0]] ? ACM_GAIN_1X : ACM_GAIN_20X))
        else $error("fixed pair gain wrong");
    route_hold_a: assert property ($past(conv_active, 2) && $past(conv_active) && conv_active
        |-> $stable(channel_code) && $stable(ref_source))
        else $error("routing changed mid conversion");
    abort_off_a: assert property (!converter_on && !$past(converter_on) |-> !conv_active)
        else $error("conversion runs while disabled");
    tick_gap_a: assert property (conv_clk_en |=> !conv_clk_en)
        else $error("converter ticks back to back");
    init_active_a: assert property (conv_init |-> conv_active)
        else $error("init flag outside conversion");
endmodule

//--- testbench/tb.sv
// self-checking bench for acm_top: apb tasks plus analog core stand-in
// assumes rtl include path for the consts header
`timescale 1ns/1ps
`include "acm_consts.svh"
module tb;
    import acm_pkg::*;
    localparam int RES_W = 10;
    localparam int TRIG_N = 8;
    localparam int CEIL = 20000;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic global_irq_enable, irq_vector_taken, conversion_irq;
    logic converter_on, conv_active, conv_init, conv_clk_en, channel_diff, temp_sensor_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [TRIG_N-1:0] trigger_in;
    logic [RES_W-1:0] result_data, exp_val;
    logic [5:0] channel_code;
    acm_ref_t ref_source;
    acm_gain_t channel_gain;
    int fail_count, tests_run, cyc, t0;

    acm_top #(.RES_W(RES_W), .TRIG_N(TRIG_N)) acm_top_inst (.core_clk(core_clk),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
        .conversion_irq(conversion_irq), .trigger_in(trigger_in), .result_data(result_data),
        .converter_on(converter_on), .conv_active(conv_active), .conv_init(conv_init),
        .conv_clk_en(conv_clk_en), .ref_source(ref_source), .channel_code(channel_code),
        .channel_diff(channel_diff), .channel_gain(channel_gain),
        .temp_sensor_en(temp_sensor_en));
    acm_core_model acm_core_model_inst (.core_clk(core_clk), .reset(reset),
        .conv_active(conv_active), .result_data(result_data), .sample_val(exp_val));

    always #12.5 core_clk = ~core_clk;

    task final_report;
        $display("mismatches %0d, comparisons %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            fail_count++;
            final_report;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_len(input int got, input int exp, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol) begin
            fail_count++;
            $display("mismatch at %0t: length %0d expected %0d", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, {24'h0, exp});
    endtask
    // registered outputs follow the register a couple of edges later
    task settle;
        repeat (3) @(posedge core_clk);
    endtask
    task rise;
        int n;
        n = 0;
        while (conv_active !== 1'b1 && n < 300) begin @(posedge core_clk); n++; end
        t0 = cyc;
        chk(32'(conv_active), 32'h1);
    endtask
    // divider code 2 in every conversion test: four cycles per tick, one tick of slack
    task fall(input int len);
        int n;
        n = 0;
        while (conv_active === 1'b1 && n < 20000) begin @(posedge core_clk); n++; end
        chk_len(cyc - t0, len * 4, 4);
    endtask

    initial begin
        int n;
        core_clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        global_irq_enable = 0; irq_vector_taken = 0; trigger_in = 0; cyc = 0;
        fail_count = 0; tests_run = 0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rdc(`ACM_ADDR_CSA, 8'h00);
        rdc(`ACM_ADDR_CRS, 8'h00);
        rdc(`ACM_ADDR_CSB, 8'h00);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        wr(`ACM_ADDR_CRS, 8'h55);
        rdc(`ACM_ADDR_CRS, 8'h55);
        for (int i = 0; i < 8; i++) begin
            wr(`ACM_ADDR_CSB, {i[2], 7'h0});
            wr(`ACM_ADDR_CRS, {i[1:0], 6'h0});
            settle;
            chk(32'(ref_source), 32'((i[2] && i[1]) ? {2'b10, i[0]} : {1'b0, i[1:0]}));
        end
        for (int c = 0; c < 64; c++) begin
            wr(`ACM_ADDR_CSB, {1'b0, c[5], c[1], 5'h0});
            wr(`ACM_ADDR_CRS, {3'h0, c[4:0]});
            settle;
            chk(32'(channel_code), 32'(c));
            chk(32'(temp_sensor_en), 32'(c == 63));
            if (c >= 32 && c < 63) chk(32'(channel_gain), 32'(((c >= 58) || !c[0])
                ? (c[1] ? ACM_GAIN_32X : ACM_GAIN_20X) : (c[1] ? ACM_GAIN_8X : ACM_GAIN_1X)));
        end
        for (int k = 0; k < 8; k++) begin
            wr(`ACM_ADDR_CSA, 8'h80 | 8'(k));
            n = 0;
            while (conv_clk_en !== 1'b1 && n < 300) begin @(posedge core_clk); n++; end
            n = 0;
            do begin @(posedge core_clk); n++; end while (conv_clk_en !== 1'b1 && n < 300);
            chk_len(n, (k < 2) ? 2 : (1 << k), 0);
            wr(`ACM_ADDR_CSA, 8'h00);
        end
        wr(`ACM_ADDR_CSB, 8'h40);
        wr(`ACM_ADDR_CRS, 8'h00);
        global_irq_enable <= 1'b1;
        wr(`ACM_ADDR_CSA, 8'hCA);
        rise;
        rdc(`ACM_ADDR_CSA, 8'hCA);
        chk(32'(conv_init), 32'h1);
        fall(25);
        rdc(`ACM_ADDR_CSA, 8'h9A);
        chk(32'(conversion_irq), 32'h1);
        rdc(`ACM_ADDR_RES_LO, exp_val[7:0]);
        rdc(`ACM_ADDR_RES_HI, {6'h0, exp_val[9:8]});
        wr(`ACM_ADDR_CRS, 8'h20);
        rdc(`ACM_ADDR_RES_LO, {exp_val[1:0], 6'h0});
        rdc(`ACM_ADDR_RES_HI, exp_val[9:2]);
        wr(`ACM_ADDR_CSA, 8'h8A);
        rdc(`ACM_ADDR_CSA, 8'h9A);
        wr(`ACM_ADDR_CSA, 8'h9A);
        rdc(`ACM_ADDR_CSA, 8'h8A);
        chk(32'(conversion_irq), 32'h0);
        wr(`ACM_ADDR_CSA, 8'hCA);
        rise;
        wr(`ACM_ADDR_CRS, 8'h7F);
        settle;
        chk(32'(channel_code), 32'h20);
        chk(32'(ref_source), 32'(ACM_REF_SUPPLY));
        fall(13);
        settle;
        chk(32'(channel_code), 32'h3F);
        chk(32'(temp_sensor_en), 32'h1);
        chk(32'(ref_source), 32'(ACM_REF_EXTERNAL));
        irq_vector_taken <= 1'b1;
        @(posedge core_clk);
        irq_vector_taken <= 1'b0;
        rdc(`ACM_ADDR_CSA, 8'h8A);
        wr(`ACM_ADDR_CSA, 8'hCA);
        rise;
        fall(25);
        wr(`ACM_ADDR_CSA, 8'hDA);
        rise;
        wr(`ACM_ADDR_CSA, 8'h0A);
        settle;
        chk(32'(conv_active), 32'h0);
        rdc(`ACM_ADDR_CSA, 8'h0A);
        wr(`ACM_ADDR_CSB, 8'h41);
        wr(`ACM_ADDR_CSA, 8'hAA);
        settle;
        trigger_in <= 8'h02;
        rise;
        fall(25);
        trigger_in <= 8'h00;
        wr(`ACM_ADDR_CSA, 8'hBA);
        trigger_in <= 8'h02;
        rise;
        fall(13);
        wr(`ACM_ADDR_CSB, 8'h40);
        wr(`ACM_ADDR_CSA, 8'hFA);
        rise;
        // free running keeps conv_active high; the flag marks each end
        n = 0;
        while (conversion_irq !== 1'b1 && n < 300) begin @(posedge core_clk); n++; end
        chk_len(cyc - t0, 13 * 4, 4);
        rdc(`ACM_ADDR_CSA, 8'hFA);
        chk(32'(conv_active), 32'h1);
        wr(`ACM_ADDR_CSA, 8'h00);
        final_report;
    end
endmodule

bind acm_top acm_checker acm_checker_inst (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .conversion_irq(conversion_irq),
    .converter_on(converter_on), .conv_active(conv_active), .conv_init(conv_init),
    .conv_clk_en(conv_clk_en), .ref_source(ref_source), .channel_code(channel_code),
    .channel_diff(channel_diff), .channel_gain(channel_gain),
    .temp_sensor_en(temp_sensor_en));
